// ===== core/sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// falling conversion_clock edges spent sampling before the null bit
`define SADC_SAMPLE_EDGES   4'h5
`define SADC_RESULT_BITS    16
`define SADC_FIFO_DEPTH     16
`define SADC_RESULT_RESET   16'h0000
`endif

// ===== core/sadc_pkg.sv
package sadc_pkg;
   typedef enum logic [2:0] {
      SADC_IDLE,
      SADC_SAMPLE,
      SADC_NULL,
      SADC_MSB,
      SADC_LSB,
      SADC_DONE
   } sadc_state_e;
endpackage : sadc_pkg

// ===== core/sadc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_out_data;
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty     = (wr_ptr == rd_ptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;

   always_comb begin
      next_wr_ptr   = wr_ptr + (AW+1)'(push);
      next_rd_ptr   = rd_ptr + (AW+1)'(pop);
      // head register loads ahead; a word written into the next head slot bypasses memory
      next_out_data = mem[next_rd_ptr[AW-1:0]];
      if (push && (wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0])) begin
         next_out_data = in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         out_data <= '0;
      end else begin
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         out_data <= next_out_data;
      end
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule : sadc_fifo
`default_nettype wire

// ===== core/sadc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_core #(
   parameter int BITS  = `SADC_RESULT_BITS,
   parameter int DEPTH = `SADC_FIFO_DEPTH
) (
   input  wire logic            clk,
   input  wire logic            resetn,
   input  wire logic            select_shutdown_n,
   input  wire logic            conversion_clock,
   output logic                 serial_out,
   output logic                 serial_out_oe,
   input  wire logic            sample_valid,
   output logic                 sample_ready,
   input  wire logic [BITS-1:0] sample_data,
   output logic                 busy
);
   localparam int CW = $clog2(BITS);

   logic                  sel_m;
   logic                  sel_s;
   logic                  clk_m;
   logic                  clk_s;
   logic                  sel_d;
   logic                  clk_d;
   logic                  sel_fall;
   logic                  clk_fall;
   logic                  fifo_valid;
   logic                  fifo_pop;
   logic [BITS-1:0]       fifo_data;
   sadc_pkg::sadc_state_e state;
   sadc_pkg::sadc_state_e next_state;
   logic [3:0]            edge_cnt;
   logic [3:0]            next_edge_cnt;
   logic [CW-1:0]         bit_idx;
   logic [CW-1:0]         next_bit_idx;
   logic [BITS-1:0]       result;
   logic [BITS-1:0]       next_result;
   logic                  next_serial_out;
   logic                  next_serial_out_oe;

   // pins are asynchronous to clk
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_m <= 1'b1;
         sel_s <= 1'b1;
         clk_m <= 1'b0;
         clk_s <= 1'b0;
         sel_d <= 1'b1;
         clk_d <= 1'b0;
      end else begin
         sel_m <= select_shutdown_n;
         sel_s <= sel_m;
         clk_m <= conversion_clock;
         clk_s <= clk_m;
         sel_d <= sel_s;
         clk_d <= clk_s;
      end
   end

   // edges are seen a few clk late, so the data clock must stay far slower
   assign sel_fall = sel_d && !sel_s;
   assign clk_fall = clk_d && !clk_s;

   // converted codes arrive from the analog side through the buffer
   sadc_fifo #(
      .WIDTH (BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // capture code at end of sampling, so it is this conversion's result
   // a pop under a rising select would lose a word that no frame carries
   assign fifo_pop = (state == sadc_pkg::SADC_SAMPLE) && clk_fall && !sel_s
                     && (edge_cnt == `SADC_SAMPLE_EDGES - 4'h1);
   assign busy     = (state != sadc_pkg::SADC_IDLE);

   always_comb begin
      next_state         = state;
      next_edge_cnt      = edge_cnt;
      next_bit_idx       = bit_idx;
      next_result        = result;
      next_serial_out    = serial_out;
      next_serial_out_oe = serial_out_oe;
      if (sel_s) begin
         next_state         = sadc_pkg::SADC_IDLE;
         next_serial_out_oe = 1'b0;
         next_serial_out    = 1'b0;
         next_edge_cnt      = 4'h0;
      end else begin
         case (state)
            sadc_pkg::SADC_IDLE: begin
               if (sel_fall) begin
                  next_state    = sadc_pkg::SADC_SAMPLE;
                  next_edge_cnt = 4'h0;
               end
            end
            sadc_pkg::SADC_SAMPLE: begin
               if (clk_fall) begin
                  next_edge_cnt = edge_cnt + 4'h1;
                  if (edge_cnt == `SADC_SAMPLE_EDGES - 4'h1) begin
                     // empty buffer yields a zero code rather than stale data
                     next_result        = fifo_valid ? fifo_data : `SADC_RESULT_RESET;
                     next_state         = sadc_pkg::SADC_NULL;
                     next_serial_out_oe = 1'b1;
                     next_serial_out    = 1'b0;
                  end
               end
            end
            sadc_pkg::SADC_NULL: begin
               if (clk_fall) begin
                  next_state      = sadc_pkg::SADC_MSB;
                  next_bit_idx    = CW'(BITS-1);
                  next_serial_out = result[BITS-1];
               end
            end
            sadc_pkg::SADC_MSB: begin
               if (clk_fall) begin
                  if (bit_idx == '0) begin
                     next_state      = sadc_pkg::SADC_LSB;
                     next_bit_idx    = '0;
                     next_serial_out = result[0];
                  end else begin
                     next_bit_idx    = bit_idx - CW'(1);
                     next_serial_out = result[bit_idx - CW'(1)];
                  end
               end
            end
            sadc_pkg::SADC_LSB: begin
               if (clk_fall) begin
                  if (bit_idx == CW'(BITS-1)) begin
                     next_state         = sadc_pkg::SADC_DONE;
                     next_serial_out_oe = 1'b0;
                     next_serial_out    = 1'b0;
                  end else begin
                     next_bit_idx    = bit_idx + CW'(1);
                     next_serial_out = result[bit_idx + CW'(1)];
                  end
               end
            end
            sadc_pkg::SADC_DONE: begin
               // repeat stream spent: stay mute until select rises
               next_state = sadc_pkg::SADC_DONE;
            end
            default: begin
               next_state = sadc_pkg::SADC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state         <= sadc_pkg::SADC_IDLE;
         edge_cnt      <= 4'h0;
         bit_idx       <= '0;
         result        <= `SADC_RESULT_RESET;
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
      end else begin
         state         <= next_state;
         edge_cnt      <= next_edge_cnt;
         bit_idx       <= next_bit_idx;
         result        <= next_result;
         serial_out    <= next_serial_out;
         serial_out_oe <= next_serial_out_oe;
      end
   end

   output_floats_a: assert property (@(posedge clk) disable iff (!resetn)
      sel_s |=> !serial_out_oe)
      else $error("output driven while deselected");
   null_low_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_NULL) |-> (serial_out_oe && !serial_out))
      else $error("null bit not low");
   enable_on_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(serial_out_oe) |-> $past(clk_fall))
      else $error("output enabled off a falling edge");
   sample_five_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(serial_out_oe) |-> $past(edge_cnt) == `SADC_SAMPLE_EDGES - 4'h1)
      else $error("sample phase length wrong");
   msb_first_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_MSB && $past(state) == sadc_pkg::SADC_NULL)
      |-> serial_out == result[BITS-1])
      else $error("first data bit not msb");
   lsb_repeat_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_LSB) |-> serial_out == result[bit_idx])
      else $error("repeat stream bit wrong");
   done_floats_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_DONE) |-> !serial_out_oe)
      else $error("output driven after repeat");
   restart_needs_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_SAMPLE && $past(state) == sadc_pkg::SADC_IDLE)
      |-> $past(sel_fall))
      else $error("conversion started without select fall");

   // sequencing checks, one or more per step of the frame, plus buffer and deselect checks
   start_on_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_IDLE && sel_fall) |=> (state == sadc_pkg::SADC_SAMPLE && busy))
      else $error("select fall did not start sampling");

   sample_bound_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_SAMPLE) |-> (edge_cnt < `SADC_SAMPLE_EDGES))
      else $error("sampling ran past its edge count");

   sample_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_SAMPLE) |-> !serial_out_oe)
      else $error("output driven while sampling");

   null_after_fifth_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_SAMPLE && clk_fall && !sel_s
       && edge_cnt == `SADC_SAMPLE_EDGES - 4'h1) |=> (state == sadc_pkg::SADC_NULL && serial_out_oe))
      else $error("null bit missing after fifth fall");

   null_to_msb_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_NULL && clk_fall && !sel_s)
      |=> (state == sadc_pkg::SADC_MSB && bit_idx == CW'(BITS-1)))
      else $error("data did not start at top bit");

   msb_stream_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_MSB) |-> (serial_out_oe && serial_out == result[bit_idx]))
      else $error("first stream bit wrong");

   msb_descends_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_MSB && clk_fall && !sel_s && bit_idx != '0)
      |=> (bit_idx == $past(bit_idx) - CW'(1)))
      else $error("first stream skipped a bit");

   bits_on_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      ($changed(serial_out) && serial_out_oe && $past(serial_out_oe)) |-> $past(clk_fall))
      else $error("output changed without a falling edge");

   lsb_entry_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_MSB && clk_fall && !sel_s && bit_idx == '0)
      |=> (state == sadc_pkg::SADC_LSB && bit_idx == '0 && serial_out == result[0]))
      else $error("repeat stream did not start at bottom bit");

   lsb_ascends_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_LSB && clk_fall && !sel_s && bit_idx != CW'(BITS-1))
      |=> (state == sadc_pkg::SADC_LSB && bit_idx == $past(bit_idx) + CW'(1)))
      else $error("repeat stream skipped a bit");

   repeat_floats_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_LSB && clk_fall && !sel_s && bit_idx == CW'(BITS-1))
      |=> (state == sadc_pkg::SADC_DONE && !serial_out_oe))
      else $error("output not floated after repeated top bit");

   done_holds_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_DONE && !sel_s) |=> (state == sadc_pkg::SADC_DONE && $stable(result)))
      else $error("finished frame reacted to a clock");

   idle_waits_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_IDLE && !sel_fall) |=> (state == sadc_pkg::SADC_IDLE))
      else $error("left idle without select fall");

   pop_captures_a: assert property (@(posedge clk) disable iff (!resetn)
      (fifo_pop && fifo_valid) |=> (result == $past(fifo_data)))
      else $error("result not taken from buffer head");

   empty_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      (fifo_pop && !fifo_valid) |=> (result == `SADC_RESULT_RESET))
      else $error("empty buffer did not give zero code");

   result_held_a: assert property (@(posedge clk) disable iff (!resetn)
      (state != sadc_pkg::SADC_SAMPLE) |=> $stable(result))
      else $error("result changed outside capture");

   idle_mute_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == sadc_pkg::SADC_IDLE) |-> (!serial_out_oe && !serial_out))
      else $error("output active while idle");

   abort_floats_a: assert property (@(posedge clk) disable iff (!resetn)
      (state != sadc_pkg::SADC_IDLE && sel_s) |=> (!serial_out_oe && !busy))
      else $error("select rise did not abandon frame");

   deselect_idles_a: assert property (@(posedge clk) disable iff (!resetn)
      sel_s |=> (state == sadc_pkg::SADC_IDLE && edge_cnt == 4'h0))
      else $error("sequencing not reset while deselected");

   oe_window_a: assert property (@(posedge clk) disable iff (!resetn)
      serial_out_oe |-> (state == sadc_pkg::SADC_NULL || state == sadc_pkg::SADC_MSB
                         || state == sadc_pkg::SADC_LSB))
      else $error("output driven outside the frame");
endmodule : sadc_core
`default_nettype wire

// ===== test/sadc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_host #(
   parameter int HALF  = 42,
   // 2000 clk is 10 us, the shortest start-to-start spacing
   parameter int FRAME = 2000
) (
   input  wire logic clk,
   output logic      select_shutdown_n,
   output logic      conversion_clock,
   input  wire logic serial_out,
   input  wire logic serial_out_oe
);
   // 84 clk a period keeps the data clock just under 2.4 MHz
   logic line;
   logic cap [1:48];
   int unsigned ticks;
   int unsigned t_start;
   assign line = serial_out_oe ? serial_out : 1'bz;
   initial begin
      select_shutdown_n = 1'b1;
      conversion_clock  = 1'b0;
      ticks             = 0;
      t_start           = 0;
   end
   always @(posedge clk) ticks <= ticks + 1;
   task automatic start();
      @(posedge clk);
      t_start = ticks;
      select_shutdown_n <= 1'b0;
   endtask : start
   task automatic pulses(input int n);
      for (int k = 1; k <= n; k++) begin
         repeat (HALF) @(posedge clk);
         conversion_clock <= 1'b1;
         cap[k] = line;
         repeat (HALF) @(posedge clk);
         conversion_clock <= 1'b0;
      end
   endtask : pulses
   task automatic stop();
      repeat (HALF) @(posedge clk);
      select_shutdown_n <= 1'b1;
      // idle gap holds select high for two data clock periods, so the core is idle before the check
      repeat (4 * HALF) @(posedge clk);
      // short frames too must keep to the conversion rate ceiling
      for (int i = 0; i < FRAME && ticks - t_start < FRAME; i++) begin
         @(posedge clk);
      end
   endtask : stop
endmodule : sadc_host
`default_nettype wire

// ===== test/sar_adc_serial_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_tb;
   logic        clk;
   logic        resetn;
   logic        select_shutdown_n;
   logic        conversion_clock;
   logic        serial_out;
   logic        serial_out_oe;
   logic        sample_valid;
   logic        sample_ready;
   logic [15:0] sample_data;
   logic        busy;
   logic [15:0] w;
   logic [15:0] words [$];
   bit          taken;
   int          failures;
   int          compares;
   integer      seed;
   sadc_core dut (
      .clk               (clk),
      .resetn            (resetn),
      .select_shutdown_n (select_shutdown_n),
      .conversion_clock  (conversion_clock),
      .serial_out        (serial_out),
      .serial_out_oe     (serial_out_oe),
      .sample_valid      (sample_valid),
      .sample_ready      (sample_ready),
      .sample_data       (sample_data),
      .busy              (busy)
   );
   sadc_host host (
      .clk               (clk),
      .select_shutdown_n (select_shutdown_n),
      .conversion_clock  (conversion_clock),
      .serial_out        (serial_out),
      .serial_out_oe     (serial_out_oe)
   );
   always #2.5 clk = ~clk;
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic exp_line(input int k, input logic [15:0] d);
      if (k < 6 || k > 38) return 1'bz;
      if (k == 6) return 1'b0;
      if (k <= 22) return d[22 - k];
      return d[k - 23];
   endfunction : exp_line
   // readiness is sampled mid-cycle so the edge decision is race free
   task automatic push(input logic [15:0] d, output bit ok);
      logic r;
      ok = 1'b0;
      sample_valid <= 1'b1;
      sample_data  <= d;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clk);
         r = sample_ready;
         @(posedge clk);
         ok = (r === 1'b1);
      end
      sample_valid <= 1'b0;
      @(posedge clk);
   endtask : push
   task automatic convert(input int n);
      logic [15:0] d;
      d = 16'h0000;
      if (n >= 5 && words.size() > 0) d = words.pop_front();
      host.start();
      host.pulses(n);
      check({15'h0000, busy}, 16'h0001);
      for (int k = 1; k <= n; k++) begin
         check({15'h0000, host.cap[k]}, {15'h0000, exp_line(k, d)});
      end
      host.stop();
      check({14'h0000, serial_out_oe, busy}, 16'h0000);
   endtask : convert
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      sample_valid = 1'b0;
      sample_data = 16'h0000;
      failures = 0;
      compares = 0;
      seed = 32'h0000_18e5;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      check({15'h0000, sample_ready}, 16'h0001);
      convert(39);
      for (int i = 0; i < 16; i++) begin
         w = (i == 0) ? 16'hffff : (i == 1) ? 16'h8000 : 16'($random(seed));
         push(w, taken);
         check({15'h0000, taken}, 16'h0001);
         if (!taken) end_sim();
         words.push_back(w);
      end
      push(16'h1234, taken);
      check({15'h0000, taken}, 16'h0000);
      // aborted before the fifth fall, so no word is consumed
      convert(3);
      convert(45);
      convert(12);
      while (words.size() > 0) begin
         convert(22 + int'($unsigned($random(seed)) % 19));
      end
      convert(39);
      end_sim();
   end
endmodule : sar_adc_serial_readout_tb
`default_nettype wire
